// ===== hw/ts_bit_timer.sv
// bit timer: phase within a bit, subcarrier and end-of-bit strobe
`timescale 1ns/1ps
module ts_bit_timer #(
    parameter int BIT_CLKS = ts_pkg::TS_BIT_CLKS
) (
    input  wire logic              clk_in,
    input  wire logic              rstn_in,
    input  wire logic              run_in,
    output ts_pkg::ts_timing_t     tim_out
);
    localparam int W = $clog2(BIT_CLKS);
    localparam int SUBW = $clog2(ts_pkg::TS_SUB_DIV);

    // quarters and subcarrier are taken from counter bits, so the period must be 2^n
    if (BIT_CLKS < ts_pkg::TS_SUB_DIV * 2 || (BIT_CLKS & (BIT_CLKS - 1)) != 0)
    begin : g_bad_period
        $error("BIT_CLKS must be a power of two of at least 32");
    end

    logic [W-1:0] cnt_reg;     // clocks into the bit
    logic [W-1:0] cnt_next;

    // counter restarts whenever the sequencer is idle
    assign cnt_next = run_in ? cnt_reg + 1'b1 : '0;

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            cnt_reg <= '0;
        else
            cnt_reg <= cnt_next;
    end

    // quarter, subcarrier (period BIT_CLKS/16) and end strobe, one driver for the struct
    assign tim_out = {cnt_reg[W-1 -: 2],
                      cnt_reg[W-SUBW-1],
                      run_in && (cnt_reg == W'(BIT_CLKS - 1))};
endmodule

// ===== hw/ts_shaper.sv
// shaper: pulse position, miller coding, envelope and inversion for one bit
`timescale 1ns/1ps
module ts_shaper (
    input  ts_pkg::ts_mod_ctrl_t cfg_in,
    input  ts_pkg::ts_timing_t   tim_in,
    input  wire logic            grp23_in,
    input  wire logic            bit_in,
    input  wire logic            prev_bit_in,
    output logic                 shaped_out
);
    logic half;        // second half of the bit
    logic win;         // quarter-long pulse window for the plain pulse types
    logic mil_win;     // window picked by modified miller
    logic pulsed;      // stream after the pulse stage
    logic env_val;     // stream after the envelope stage

    assign half = tim_in.quarter[1];

    // quarter 0, 2 or 3 carries the pulse
    always_comb
    begin
        case (cfg_in.pulse)
            ts_pkg::TS_PULSE_START:  win = (tim_in.quarter == 2'h0);  // R01
            ts_pkg::TS_PULSE_HALF2:  win = (tim_in.quarter == 2'h2);  // R01
            ts_pkg::TS_PULSE_QUART3: win = (tim_in.quarter == 2'h3);  // R01
            default:                 win = 1'b0;
        endcase
    end

    // one: mid-bit pulse; zero: start pulse unless a one came just before
    assign mil_win = bit_in ? (tim_in.quarter == 2'h2)
                            : (!prev_bit_in && tim_in.quarter == 2'h0);  // R02 R07

    assign pulsed = (cfg_in.pulse == ts_pkg::TS_PULSE_NONE) ? bit_in
                  : cfg_in.miller ? mil_win                              // R02 R07
                  : (bit_in && win);                                     // R01 R06

    // envelope combined with the pulsed stream
    always_comb
    begin
        case (cfg_in.env)
            ts_pkg::TS_ENV_DIRECT:    env_val = pulsed;                  // R05 R09
            ts_pkg::TS_ENV_MANCH:     env_val = pulsed ^ half;           // R05 R09
            ts_pkg::TS_ENV_MANCH_SUB: env_val = (pulsed ^ half) & tim_in.sub;
            ts_pkg::TS_ENV_BPSK:      env_val = pulsed ^ tim_in.sub;     // R05 R09
            ts_pkg::TS_ENV_RZ_LATE:   env_val = pulsed & half;           // R05 R09
            ts_pkg::TS_ENV_RZ_ALT:    env_val = pulsed & (grp23_in ? !half : half); // R10
            default:                  env_val = 1'b0;  // reserved: zero here, so only inversion can drive the carrier
        endcase
    end

    // inversion is the very last stage
    assign shaped_out = env_val ^ cfg_in.invert;  // R04 R08 R15
endmodule

// ===== hw/ts_symbol_shaper.sv
// transmit symbol shaper: control registers, symbol sequencer, shaped output
//
// Operation
// [R01] pulse field 01 picks pulse start position
// [R02] miller bit 01 applies modified miller pulses
// [R03] software sets miller 01 only with pulse 1
// [R04] invert bit 01 inverts symbols zero, one
// [R05] envelope 01: direct, manchester, subcarrier, bpsk, rz
// [R06] pulse field 23 uses the same encoding
// [R07] miller bit 23 applies miller, pulse 1 only
// [R08] invert bit 23 inverts symbols two, three
// [R09] envelope 23: same codes, 6 and 7 reserved
// [R10] envelope 23 value 5: rz at bit start
// [R11] miller bit 6, pulse 5:4, envelope 2:0
// [R12] length 01 code n gives n+1 bits
// [R13] length 23 code n gives n+1 bits
// [R14] burst alone sends burst without pattern
// [R15] inversion applied after all other shaping
// [R16] bit 7 of modulation registers reads zero
`timescale 1ns/1ps
module ts_symbol_shaper #(
    parameter int BIT_CLKS = ts_pkg::TS_BIT_CLKS
) (
    input  wire logic       clk_in,
    input  wire logic       rstn_in,
    input  wire logic [7:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    output logic      [7:0] rdata_out,
    input  wire logic       sym_start_in,
    input  wire logic [1:0] sym_sel_in,
    output logic            mod_out,
    output logic            busy_out,
    output logic            done_out
);

    ////////////////////////////////////////////////////////////////////////////
    // registers

    logic [7:0] pat0h_reg;   // pattern of symbol zero, high byte
    logic [7:0] pat0l_reg;   // pattern of symbol zero, low byte
    logic [7:0] pat1h_reg;   // pattern of symbol one, high byte
    logic [7:0] pat1l_reg;   // pattern of symbol one, low byte
    logic [7:0] pat2_reg;    // pattern of symbol two
    logic [7:0] pat3_reg;    // pattern of symbol three
    logic [7:0] len10_reg;   // lengths of symbols one and zero
    logic [7:0] len32_reg;   // lengths of symbols three and two
    logic [7:0] burst_reg;   // burst options
    ts_pkg::ts_mod_ctrl_t mod01_reg;  // group zero/one modulation
    ts_pkg::ts_mod_ctrl_t mod23_reg;  // group two/three modulation

    logic [7:0] rd_mux;      // read data selected this cycle
    logic [7:0] stat_val;    // live status word

    // bits a symbol carries; used by the loader and by a check
    function automatic logic [4:0] sym_bits(input logic [1:0] sel,
                                            input logic [7:0] l10,
                                            input logic [7:0] l32);
        case (sel)
            2'h0:    sym_bits = {1'b0, l10[3:0]} + 5'h01;                   // R12
            2'h1:    sym_bits = {1'b0, l10[7:4]} + 5'h01;                   // R12
            2'h2:    sym_bits = {2'b00, l32[2:0]} + 5'h01;                  // R13
            default: sym_bits = {2'b00, l32[6:4]} + 5'h01;                  // R13
        endcase
    endfunction

    // write decode; reserved bits are masked on the way in
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            pat0h_reg <= ts_pkg::TS_REG_RST;
            pat0l_reg <= ts_pkg::TS_REG_RST;
            pat1h_reg <= ts_pkg::TS_REG_RST;
            pat1l_reg <= ts_pkg::TS_REG_RST;
            pat2_reg  <= ts_pkg::TS_REG_RST;
            pat3_reg  <= ts_pkg::TS_REG_RST;
            len10_reg <= ts_pkg::TS_REG_RST;
            len32_reg <= ts_pkg::TS_REG_RST;
            burst_reg <= ts_pkg::TS_REG_RST;
            mod01_reg <= ts_pkg::TS_REG_RST;
            mod23_reg <= ts_pkg::TS_REG_RST;
        end
        else if (wr_in)
        begin
            case (addr_in)
                ts_pkg::TS_PAT0H_OFS: pat0h_reg <= wdata_in;
                ts_pkg::TS_PAT0L_OFS: pat0l_reg <= wdata_in;
                ts_pkg::TS_PAT1H_OFS: pat1h_reg <= wdata_in;
                ts_pkg::TS_PAT1L_OFS: pat1l_reg <= wdata_in;
                ts_pkg::TS_PAT2_OFS:  pat2_reg  <= wdata_in;
                ts_pkg::TS_PAT3_OFS:  pat3_reg  <= wdata_in;
                ts_pkg::TS_LEN10_OFS: len10_reg <= wdata_in;
                ts_pkg::TS_LEN32_OFS: len32_reg <= wdata_in & ts_pkg::TS_RSV37_MASK;
                ts_pkg::TS_BURST_OFS: burst_reg <= wdata_in & ts_pkg::TS_RSV37_MASK;
                ts_pkg::TS_MOD01_OFS: mod01_reg <= wdata_in & ts_pkg::TS_MOD_MASK; // R11 R16
                ts_pkg::TS_MOD23_OFS: mod23_reg <= wdata_in & ts_pkg::TS_MOD_MASK; // R11 R16
                default:              ;  // unmapped writes are dropped
            endcase
        end
    end

    // read mux; unmapped offsets read zero
    assign rd_mux =
        (addr_in == ts_pkg::TS_PAT0H_OFS) ? pat0h_reg :
        (addr_in == ts_pkg::TS_PAT0L_OFS) ? pat0l_reg :
        (addr_in == ts_pkg::TS_PAT1H_OFS) ? pat1h_reg :
        (addr_in == ts_pkg::TS_PAT1L_OFS) ? pat1l_reg :
        (addr_in == ts_pkg::TS_PAT2_OFS)  ? pat2_reg  :
        (addr_in == ts_pkg::TS_PAT3_OFS)  ? pat3_reg  :
        (addr_in == ts_pkg::TS_LEN10_OFS) ? len10_reg :
        (addr_in == ts_pkg::TS_LEN32_OFS) ? len32_reg :
        (addr_in == ts_pkg::TS_BURST_OFS) ? burst_reg :
        (addr_in == ts_pkg::TS_MOD01_OFS) ? mod01_reg :  // R16
        (addr_in == ts_pkg::TS_MOD23_OFS) ? mod23_reg :  // R16
        (addr_in == ts_pkg::TS_STAT_OFS)  ? stat_val  : 8'h00;

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            rdata_out <= 8'h00;
        else
            rdata_out <= rd_in ? rd_mux : 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////
    // symbol sequencer

    ts_pkg::ts_state_t  state_reg;   // idle or sending
    ts_pkg::ts_state_t  state_next;
    logic [1:0]  sel_reg;            // symbol being sent
    logic [15:0] shift_reg;          // pattern, lsb goes out first
    logic [4:0]  left_reg;           // bits still to send after this one
    logic        prev_bit_reg;       // previous bit, for miller
    logic        start_ok;           // start accepted this cycle
    logic        alone;              // chosen symbol is burst only
    logic        burst_lvl;          // burst level of chosen symbol
    logic [15:0] pat_sel;            // pattern of chosen symbol
    logic        last_bit;           // current bit is the final one
    logic        cur_bit;            // bit now being shaped
    ts_pkg::ts_timing_t   tim;       // phase within the bit
    ts_pkg::ts_mod_ctrl_t act_cfg;   // group of the symbol in flight
    logic        shaped;             // shaper result

    assign start_ok  = sym_start_in && (state_reg == ts_pkg::TS_IDLE);
    assign alone     = sym_sel_in == 2'h0 ? burst_reg[ts_pkg::TS_ALONE0_POS]
                     : sym_sel_in == 2'h1 ? burst_reg[ts_pkg::TS_ALONE1_POS] : 1'b0;
    assign burst_lvl = sym_sel_in == 2'h0 ? burst_reg[ts_pkg::TS_TYPE0_POS]
                                          : burst_reg[ts_pkg::TS_TYPE1_POS];
    assign pat_sel   = sym_sel_in == 2'h0 ? {pat0h_reg, pat0l_reg}
                     : sym_sel_in == 2'h1 ? {pat1h_reg, pat1l_reg}
                     : sym_sel_in == 2'h2 ? {8'h00, pat2_reg} : {8'h00, pat3_reg};
    assign last_bit  = (left_reg == 5'h00);
    assign cur_bit   = shift_reg[0];
    assign act_cfg   = sel_reg[1] ? mod23_reg : mod01_reg;
    assign stat_val  = {5'h00, busy_out, sel_reg};  // status: busy and last symbol

    // a start request while busy is ignored
    always_comb
    begin
        case (state_reg)
            ts_pkg::TS_IDLE: state_next = start_ok ? ts_pkg::TS_SEND : ts_pkg::TS_IDLE;
            ts_pkg::TS_SEND: state_next = (tim.bit_end && last_bit) ? ts_pkg::TS_IDLE
                                                                     : ts_pkg::TS_SEND;
            default:         state_next = ts_pkg::TS_IDLE;
        endcase
    end

    // load on start, shift at each bit end
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            state_reg    <= ts_pkg::TS_IDLE;
            sel_reg      <= 2'h0;
            shift_reg    <= 16'h0000;
            left_reg     <= 5'h00;
            prev_bit_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            if (start_ok)
            begin
                sel_reg   <= sym_sel_in;
                shift_reg <= alone ? {15'h0000, burst_lvl} : pat_sel;        // R14
                left_reg  <= alone ? 5'h00
                           : sym_bits(sym_sel_in, len10_reg, len32_reg) - 5'h01; // R12 R13
            end
            else if (tim.bit_end)
            begin
                shift_reg    <= {1'b0, shift_reg[15:1]};
                left_reg     <= last_bit ? 5'h00 : left_reg - 5'h01;
                prev_bit_reg <= cur_bit;  // R02 R07
            end
        end
    end

    ts_bit_timer #(
        .BIT_CLKS (BIT_CLKS)
    ) u_timer (
        .clk_in  (clk_in),
        .rstn_in (rstn_in),
        .run_in  (state_reg == ts_pkg::TS_SEND),
        .tim_out (tim)
    );

    ts_shaper u_shaper (
        .cfg_in      (act_cfg),
        .tim_in      (tim),
        .grp23_in    (sel_reg[1]),
        .bit_in      (cur_bit),
        .prev_bit_in (prev_bit_reg),
        .shaped_out  (shaped)
    );

    // outputs straight from flops; line is quiet while idle
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            mod_out  <= 1'b0;
            busy_out <= 1'b0;
            done_out <= 1'b0;
        end
        else
        begin
            mod_out  <= (state_reg == ts_pkg::TS_SEND) ? shaped : 1'b0;  // R15
            busy_out <= (state_next == ts_pkg::TS_SEND);
            done_out <= (state_reg == ts_pkg::TS_SEND) && tim.bit_end && last_bit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    logic       sending;        // sequencer in the send state
    logic [4:0] sent_reg;       // bits finished in this symbol
    logic [4:0] expect_reg;     // bits the symbol should carry
    logic       alone_reg;      // symbol in flight is burst only

    assign sending = (state_reg == ts_pkg::TS_SEND);

    // counts bits independently of the sequencer
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            sent_reg   <= 5'h00;
            expect_reg <= 5'h00;
            alone_reg  <= 1'b0;
        end
        else if (start_ok)
        begin
            sent_reg   <= 5'h00;
            expect_reg <= sym_bits(sym_sel_in, len10_reg, len32_reg);
            alone_reg  <= alone;
        end
        else if (tim.bit_end)
            sent_reg <= sent_reg + 5'h01;
    end

    property p_len_count;
        @(posedge clk_in) disable iff (!rstn_in)
        done_out && !alone_reg |-> sent_reg == expect_reg;
    endproperty
    a_len_count: assert property (p_len_count) else $error("wrong bit count"); // R12 R13

    property p_burst_one;
        @(posedge clk_in) disable iff (!rstn_in)
        done_out && alone_reg |-> sent_reg == 5'h01;
    endproperty
    a_burst_one: assert property (p_burst_one) else $error("burst not one bit"); // R14

    property p_invert;
        @(posedge clk_in) disable iff (!rstn_in)
        sending && act_cfg.invert && act_cfg.env == ts_pkg::TS_ENV_DIRECT
            && act_cfg.pulse == ts_pkg::TS_PULSE_NONE |=> mod_out == !$past(cur_bit);
    endproperty
    a_invert: assert property (p_invert) else $error("output not inverted"); // R04 R08 R15

    property p_manch;
        @(posedge clk_in) disable iff (!rstn_in)
        sending && !act_cfg.invert && act_cfg.env == ts_pkg::TS_ENV_MANCH
            && act_cfg.pulse == ts_pkg::TS_PULSE_NONE
            |=> mod_out == ($past(cur_bit) ^ $past(tim.quarter[1]));
    endproperty
    a_manch: assert property (p_manch) else $error("manchester wrong"); // R05 R09

    property p_rz_alt23;
        @(posedge clk_in) disable iff (!rstn_in)
        sending && sel_reg[1] && !act_cfg.invert && act_cfg.env == ts_pkg::TS_ENV_RZ_ALT
            && act_cfg.pulse == ts_pkg::TS_PULSE_NONE && tim.quarter[1] |=> !mod_out;
    endproperty
    a_rz_alt23: assert property (p_rz_alt23) else $error("rz pulse in second half"); // R10

    property p_pulse_pos;
        @(posedge clk_in) disable iff (!rstn_in)
        sending && !act_cfg.invert && !act_cfg.miller && act_cfg.env == ts_pkg::TS_ENV_DIRECT
            && act_cfg.pulse == ts_pkg::TS_PULSE_HALF2 && tim.quarter != 2'h2 |=> !mod_out;
    endproperty
    a_pulse_pos: assert property (p_pulse_pos) else $error("pulse outside window"); // R01 R06

    property p_miller;
        @(posedge clk_in) disable iff (!rstn_in)
        sending && act_cfg.miller && !act_cfg.invert && act_cfg.env == ts_pkg::TS_ENV_DIRECT
            && act_cfg.pulse == ts_pkg::TS_PULSE_START && prev_bit_reg && !cur_bit
            |=> !mod_out;
    endproperty
    a_miller: assert property (p_miller) else $error("miller zero after one pulsed"); // R02 R07

    property p_rsvd_zero;
        @(posedge clk_in) disable iff (!rstn_in)
        rd_in && (addr_in == ts_pkg::TS_MOD01_OFS || addr_in == ts_pkg::TS_MOD23_OFS)
            |=> !rdata_out[7];
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit reads one"); // R16

    property p_field_back;
        @(posedge clk_in) disable iff (!rstn_in)
        wr_in && addr_in == ts_pkg::TS_MOD01_OFS ##1 rd_in && addr_in == ts_pkg::TS_MOD01_OFS
            |=> rdata_out == ($past(wdata_in, 2) & ts_pkg::TS_MOD_MASK);
    endproperty
    a_field_back: assert property (p_field_back) else $error("fields not kept"); // R11

    property p_idle_quiet;
        @(posedge clk_in) disable iff (!rstn_in)
        !sending |=> !mod_out;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("output active while idle");

    c_sym0: cover property (@(posedge clk_in) disable iff (!rstn_in)
        start_ok && sym_sel_in == 2'h0 ##[1:1000] done_out);
    c_miller: cover property (@(posedge clk_in) disable iff (!rstn_in)
        sending && act_cfg.miller && mod_out);
    c_burst: cover property (@(posedge clk_in) disable iff (!rstn_in)
        done_out && alone_reg);
    c_rz23: cover property (@(posedge clk_in) disable iff (!rstn_in)
        sending && sel_reg[1] && act_cfg.env == ts_pkg::TS_ENV_RZ_ALT && mod_out);

endmodule

// ===== include/ts_pkg.sv
// package: register map, field layout, encodings and timing of the symbol shaper
package ts_pkg;

    // register offsets on the 8-bit control port
    localparam logic [7:0] TS_PAT0H_OFS = 8'h4d;
    localparam logic [7:0] TS_PAT0L_OFS = 8'h4e;
    localparam logic [7:0] TS_PAT1H_OFS = 8'h4f;
    localparam logic [7:0] TS_PAT1L_OFS = 8'h50;
    localparam logic [7:0] TS_PAT2_OFS  = 8'h51;
    localparam logic [7:0] TS_PAT3_OFS  = 8'h52;
    localparam logic [7:0] TS_LEN10_OFS = 8'h53;
    localparam logic [7:0] TS_LEN32_OFS = 8'h54;
    localparam logic [7:0] TS_BURST_OFS = 8'h55;
    localparam logic [7:0] TS_MOD01_OFS = 8'h56;
    localparam logic [7:0] TS_MOD23_OFS = 8'h57;
    localparam logic [7:0] TS_STAT_OFS  = 8'h5f;

    // field positions
    localparam int TS_MILLER_POS  = 6;
    localparam int TS_PULSE_POS   = 4;
    localparam int TS_INVERT_POS  = 3;
    localparam int TS_ENV_POS     = 0;
    localparam int TS_LEN1_POS    = 4;
    localparam int TS_ALONE0_POS  = 1;
    localparam int TS_TYPE0_POS   = 2;
    localparam int TS_ALONE1_POS  = 5;
    localparam int TS_TYPE1_POS   = 6;

    // writable masks: reserved bits stay zero
    localparam logic [7:0] TS_MOD_MASK   = 8'h7f;
    localparam logic [7:0] TS_RSV37_MASK = 8'h77;

    // reset values of every register
    localparam logic [7:0] TS_REG_RST = 8'h00;

    // bit period in clocks, power of two; subcarrier is 1/16 of it
    localparam int TS_BIT_CLKS = 128;
    localparam int TS_SUB_DIV  = 16;

    typedef enum logic [1:0] {
        TS_PULSE_NONE,
        TS_PULSE_START,
        TS_PULSE_HALF2,
        TS_PULSE_QUART3
    } ts_pulse_t;

    typedef enum logic [2:0] {
        TS_ENV_DIRECT,
        TS_ENV_MANCH,
        TS_ENV_MANCH_SUB,
        TS_ENV_BPSK,
        TS_ENV_RZ_LATE,
        TS_ENV_RZ_ALT,
        TS_ENV_RSV6,
        TS_ENV_RSV7
    } ts_env_t;

    // one modulation control register
    typedef struct packed {
        logic      rsvd;
        logic      miller;
        ts_pulse_t pulse;
        logic      invert;
        ts_env_t   env;
    } ts_mod_ctrl_t;

    // position inside the current bit
    typedef struct packed {
        logic [1:0] quarter;
        logic       sub;
        logic       bit_end;
    } ts_timing_t;

    typedef enum logic {
        TS_IDLE,
        TS_SEND
    } ts_state_t;

endpackage

// ===== tb/tb.sv
// testbench: register access and symbol shaping checks of the symbol shaper
`timescale 1ns/1ps
module tb;
    localparam int BC = 32;  // short bit period keeps the run brief
    logic        clk_in = 1'b0;
    logic        rstn_in = 1'b0;
    logic [7:0]  addr_in = 8'h00;
    logic [7:0]  wdata_in = 8'h00;
    logic        wr_in = 1'b0;
    logic        rd_in = 1'b0;
    logic        sym_start_in = 1'b0;
    logic [1:0]  sym_sel_in = 2'h0;
    logic [7:0]  rdata_out;
    logic        mod_out, busy_out, done_out;
    logic [15:0] hi, first, len;  // partner measurements
    int          error_cnt = 0;
    int          n_compared = 0;

    ts_symbol_shaper #(.BIT_CLKS(BC)) uut (.clk_in(clk_in), .rstn_in(rstn_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .sym_start_in(sym_start_in), .sym_sel_in(sym_sel_in),
        .mod_out(mod_out), .busy_out(busy_out), .done_out(done_out));
    ts_rf_model #(.HALF(BC / 2)) rf (.clk_in(clk_in), .rstn_in(rstn_in), .mod_in(mod_out),
        .act_in(busy_out | done_out), .hi_out(hi), .first_out(first), .len_out(len));

    always #5 clk_in = ~clk_in;

    ////////////////////////////////////////////////////////////////////////
    // end of run, also reached by a hung wait
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 chk("rdata", {8'h00, e}, {8'h00, rdata_out});
    endtask

    // write then read back with no gap between the strobes
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
        @(posedge clk_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 chk("rdata", {8'h00, e}, {8'h00, rdata_out});
    endtask

    // set a group's control, send symbol s, compare energy, position, length
    // ef: 1 early half, 0 late half, 2 position not checked
    task automatic mc(input logic [1:0] s, input logic [7:0] m, input logic [15:0] eh,
                      input logic [1:0] ef, input logic [15:0] el);
        int k;
        wr(s[1] ? ts_pkg::TS_MOD23_OFS : ts_pkg::TS_MOD01_OFS, m);
        @(posedge clk_in);
        sym_sel_in   <= s;
        sym_start_in <= 1'b1;
        @(posedge clk_in);
        sym_start_in <= 1'b0;
        #1 chk("busy", 16'h0001, {15'h0000, busy_out});
        k = 0;
        while (done_out !== 1'b1 && k < 20000)
        begin
            @(posedge clk_in);
            #1 k++;
        end
        if (k == 20000)
        begin
            error_cnt++;
            $display("mismatch done expected 1 seen timeout");
            give_verdict();
        end
        @(posedge clk_in);
        #1 chk("high", eh, hi);
        chk("length", el, len);
        if (ef != 2'd2)
            chk("early", 16'(ef), 16'(first * 2 > hi));
        $display("test symbol %0d control %h done", s, m);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (2) @(posedge clk_in);
        rstn_in <= 1'b1;
        rd(ts_pkg::TS_MOD01_OFS, 8'h00);
        rd(ts_pkg::TS_MOD23_OFS, 8'h00);
        wr_rd(ts_pkg::TS_MOD01_OFS, 8'hff, 8'h7f);
        wr(ts_pkg::TS_MOD23_OFS, 8'hd5);
        rd(ts_pkg::TS_MOD23_OFS, 8'h55);
        rd(8'h60, 8'h00);
        $display("test registers done");
        // one-bit symbols carrying a single one
        wr(ts_pkg::TS_PAT0L_OFS, 8'h01);
        wr(ts_pkg::TS_PAT2_OFS, 8'h01);
        mc(2, 8'h00, 32, 2, BC + 1);
        mc(2, 8'h08, 0, 2, BC + 1);
        mc(2, 8'h01, 16, 1, BC + 1);
        mc(2, 8'h02, 8, 2, BC + 1);
        mc(2, 8'h03, 16, 2, BC + 1);
        mc(2, 8'h04, 16, 0, BC + 1);
        mc(2, 8'h05, 16, 1, BC + 1);
        mc(2, 8'h06, 0, 2, BC + 1);
        mc(2, 8'h07, 0, 2, BC + 1);
        mc(2, 8'h10, 8, 1, BC + 1);
        mc(2, 8'h20, 8, 0, BC + 1);
        mc(2, 8'h30, 8, 0, BC + 1);
        mc(2, 8'h0c, 16, 1, BC + 1);
        mc(0, 8'h00, 32, 2, BC + 1);
        mc(0, 8'h08, 0, 2, BC + 1);
        mc(0, 8'h01, 16, 1, BC + 1);
        mc(0, 8'h02, 8, 2, BC + 1);
        mc(0, 8'h03, 16, 2, BC + 1);
        mc(0, 8'h04, 16, 0, BC + 1);
        mc(0, 8'h05, 16, 0, BC + 1);
        mc(0, 8'h10, 8, 1, BC + 1);
        mc(0, 8'h20, 8, 0, BC + 1);
        mc(0, 8'h30, 8, 0, BC + 1);
        // three bits 1,0,0: miller adds a pulse on the second zero
        wr(ts_pkg::TS_LEN10_OFS, 8'h02);
        wr(ts_pkg::TS_LEN32_OFS, 8'h02);
        mc(0, 8'h10, 8, 2, 3 * BC + 1);
        mc(0, 8'h50, 16, 2, 3 * BC + 1);
        mc(2, 8'h50, 16, 2, 3 * BC + 1);
        // long lengths: symbol zero and symbol three at their longest
        wr(ts_pkg::TS_LEN10_OFS, 8'h1f);
        wr(ts_pkg::TS_LEN32_OFS, 8'h72);
        wr(ts_pkg::TS_PAT1L_OFS, 8'h02);
        wr(ts_pkg::TS_PAT3_OFS, 8'h80);
        mc(0, 8'h00, 32, 2, 16 * BC + 1);
        mc(1, 8'h00, 32, 2, 2 * BC + 1);
        mc(2, 8'h00, 32, 2, 3 * BC + 1);
        mc(3, 8'h00, 32, 2, 8 * BC + 1);
        rd(ts_pkg::TS_STAT_OFS, 8'h03);
        // burst alone replaces the pattern with one bit of the burst type
        wr(ts_pkg::TS_BURST_OFS, 8'h06);
        mc(0, 8'h00, 32, 2, BC + 1);
        wr(ts_pkg::TS_BURST_OFS, 8'h02);
        mc(0, 8'h00, 0, 2, BC + 1);
        give_verdict();
    end
endmodule

// ===== tb/ts_rf_model.sv
// rf transmitter stage model: measures the shaped stream of one symbol
`timescale 1ns/1ps
module ts_rf_model #(
    parameter int HALF = 16
) (
    input  wire logic        clk_in,
    input  wire logic        rstn_in,
    input  wire logic        mod_in,
    input  wire logic        act_in,
    output logic      [15:0] hi_out,
    output logic      [15:0] first_out,
    output logic      [15:0] len_out
);
    logic act_d;  // activity one cycle ago, marks a new symbol

    ////////////////////////////////////////////////////////////////////////
    // counters restart per symbol and then hold for the bench to read
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            act_d     <= 1'b0;
            hi_out    <= '0;
            first_out <= '0;
            len_out   <= '0;
        end
        else
        begin
            act_d <= act_in;
            if (act_in && !act_d)
            begin
                // first active cycle of a symbol
                hi_out    <= 16'(mod_in);
                first_out <= 16'(mod_in);
                len_out   <= 16'd1;
            end
            else if (act_in)
            begin
                // carrier energy over the whole symbol, and separately over its first HALF cycles
                hi_out  <= hi_out + 16'(mod_in);
                len_out <= len_out + 16'd1;
                if (len_out < 16'(HALF))
                begin
                    first_out <= first_out + 16'(mod_in);
                end
            end
        end
    end
endmodule
